// >>> hdl/mdu_pkg.sv
package mdu_pkg;

  // ==========================================================================
  // Register indices; the APB byte address is four times the index
  // ==========================================================================
  localparam logic [7:0]  IDX_OPERAND_BYTE0 = 8'hF9;
  localparam logic [7:0]  IDX_OPERAND_BYTE1 = 8'hFA;
  localparam logic [7:0]  IDX_OPERAND_BYTE2 = 8'hFB;
  localparam logic [7:0]  IDX_OPERAND_BYTE3 = 8'hFC;
  localparam logic [7:0]  IDX_OPERAND_BYTE4 = 8'hFD;
  localparam logic [7:0]  IDX_OPERAND_BYTE5 = 8'hFE;
  localparam logic [7:0]  IDX_ARITH_CONTROL = 8'hFF;
  localparam int unsigned ADDR_W            = 12;

  // ==========================================================================
  // Control register fields and reset values
  // ==========================================================================
  localparam int unsigned ARC_ERR_BIT   = 7;
  localparam int unsigned ARC_OVF_BIT   = 6;
  localparam int unsigned ARC_SLR_BIT   = 5;
  localparam int unsigned ARC_SC_MSB    = 4;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [47:0] RST_OPERANDS  = 48'h0;
  localparam logic [4:0]  RST_SC        = 5'h00;

  // ==========================================================================
  // Latencies in clock cycles, counted from the final loading write
  // ==========================================================================
  localparam logic [4:0]  LAT_DIV32     = 5'h11;
  localparam logic [4:0]  LAT_DIV16     = 5'h09;
  localparam logic [4:0]  LAT_MUL       = 5'h0A;
  localparam logic [4:0]  LAT_SHIFT     = 5'h03;
  localparam logic [4:0]  CNT_ONE       = 5'h01;
  localparam logic [15:0] PROD_LIMIT    = 16'hFFFF;

  // ==========================================================================
  // Sequence phases and operations
  // ==========================================================================
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_LOAD   = 2'b01,
    PH_BUSY   = 2'b10,
    PH_RESULT = 2'b11
  } phase_e;

  typedef enum logic [2:0] {
    OP_DIV32 = 3'b000,
    OP_DIV16 = 3'b001,
    OP_MUL   = 3'b010,
    OP_NORM  = 3'b011,
    OP_SHIFT = 3'b100
  } op_e;

endpackage : mdu_pkg

// >>> hdl/mul_div_shift_unit.sv
`timescale 1ns/10ps
// How it works
// - 32/16 division gives 32-bit quotient and 16-bit remainder within 17 cycles.
// - 16/16 division gives 16-bit quotient and remainder within 9 cycles.
// - 16x16 multiplication gives a 32-bit product within 10 cycles.
// - Latency is counted from the last write of the loading sequence.
// - Error flag sets on operand write while busy; clears when control is read.
// - Overflow flag: zero divisor, product above 0xFFFF, or already normalized operand.
// - Direction bit one shifts right, zero shifts left.
// - Count zero starts normalization returning shift count; nonzero shifts by count.
// - Opening byte 0 write resets the unit; final loading write starts work.
// - After division bytes 0-3 hold quotient, bytes 4-5 hold remainder.
// - Finishing the result reads leaves the unit ready for the next operation.
// - After multiplication bytes 0-3 hold the product, low byte first.
// - Normalization shifts out leading zeros, stores result, records zero count.
// - Control write after loading bytes 0-3 starts the shift; result returns there.
// - Error tracking spans opening write to last read; good sequences clear it.

module mul_div_shift_unit (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mdu_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [47:0]     md;
    logic            err;
    logic            ovf;
    logic            shift_direction_select;
    logic [4:0]      sc;
    mdu_pkg::phase_e phase;
    mdu_pkg::op_e    op;
    logic [4:0]      cnt;
    logic            hi_seen;
    logic            wr1_seen;
    logic            mul_ord;
    logic [7:0]      rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic [7:0]  idx;
  logic        idx_ok;
  logic        wr_acc;
  logic        rd_acc;
  logic        setup;
  logic [7:0]  wbyte;
  logic [7:0]  arc_rd;
  logic [7:0]  rd_mux;
  logic [31:0] dvd32;
  logic [15:0] dvs;
  logic        dvs_zero;
  logic [31:0] q32;
  logic [15:0] r32;
  logic [15:0] q16;
  logic [15:0] r16;
  logic [31:0] prod;
  logic [4:0]  lz;
  logic        opnd_zero;
  logic [31:0] norm_res;
  logic [31:0] shift_res;
  logic        done;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  assign idx    = paddr[9:2];
  assign idx_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  (idx >= mdu_pkg::IDX_OPERAND_BYTE0);
  assign wr_acc = psel && penable && pwrite && idx_ok;
  assign rd_acc = psel && penable && !pwrite && idx_ok;
  assign setup  = psel && !penable;
  assign wbyte  = pwdata[7:0];

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !idx_ok;
  assign prdata  = {24'h000000, st_ff.rdata};

  assign arc_rd = {st_ff.err, st_ff.ovf, st_ff.shift_direction_select, st_ff.sc};

  always_comb
  begin
    rd_mux = mdu_pkg::RST_BYTE;
    if (idx_ok)
    begin
      unique case (idx)
        mdu_pkg::IDX_OPERAND_BYTE0: rd_mux = st_ff.md[7:0];
        mdu_pkg::IDX_OPERAND_BYTE1: rd_mux = st_ff.md[15:8];
        mdu_pkg::IDX_OPERAND_BYTE2: rd_mux = st_ff.md[23:16];
        mdu_pkg::IDX_OPERAND_BYTE3: rd_mux = st_ff.md[31:24];
        mdu_pkg::IDX_OPERAND_BYTE4: rd_mux = st_ff.md[39:32];
        mdu_pkg::IDX_OPERAND_BYTE5: rd_mux = st_ff.md[47:40];
        default:                    rd_mux = arc_rd;
      endcase
    end
  end

  // ==========================================================================
  // Datapath; operands are frozen while busy, so results are taken at the end
  // ==========================================================================
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       hit;
    n   = 5'h00;
    hit = 1'b0;
    for (int i = 31; i > 0; i--)
    begin
      if (!hit && !v[i])
        n = n + 5'h01;
      else
        hit = 1'b1;
    end
    return n;
  endfunction : lead_zeros

  assign dvd32    = st_ff.md[31:0];
  assign dvs      = st_ff.md[47:32];
  assign dvs_zero = (dvs == 16'h0000);
  // A zero divisor yields zero results; only the overflow flag reports it
  assign q32      = dvs_zero ? 32'h0 : dvd32 / {16'h0000, dvs};
  assign r32      = dvs_zero ? 16'h0 : 16'(dvd32 % {16'h0000, dvs});
  assign q16      = dvs_zero ? 16'h0 : st_ff.md[15:0] / dvs;
  assign r16      = dvs_zero ? 16'h0 : st_ff.md[15:0] % dvs;
  assign prod     = {16'h0000, st_ff.md[15:0]} * {16'h0000, dvs};
  assign lz       = lead_zeros(dvd32);
  assign opnd_zero = (dvd32 == 32'h0);
  assign norm_res = dvd32 << lz;
  assign shift_res = st_ff.shift_direction_select ? (dvd32 >> st_ff.sc) : (dvd32 << st_ff.sc);
  assign done     = (st_ff.phase == mdu_pkg::PH_BUSY) && (st_ff.cnt == 5'h00);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    nxt_st = st_ff;
    if (setup)
      nxt_st.rdata = rd_mux;

    if (st_ff.phase == mdu_pkg::PH_BUSY)
    begin
      if (!done)
        nxt_st.cnt = st_ff.cnt - mdu_pkg::CNT_ONE;
      else
      begin
        nxt_st.phase = mdu_pkg::PH_RESULT;
        unique case (st_ff.op)
          mdu_pkg::OP_DIV32:
          begin
            nxt_st.md  = {r32, q32};
            nxt_st.ovf = dvs_zero;
          end
          mdu_pkg::OP_DIV16:
          begin
            nxt_st.md  = {r16, 16'h0000, q16};
            nxt_st.ovf = dvs_zero;
          end
          mdu_pkg::OP_MUL:
          begin
            nxt_st.md[31:0] = prod;
            nxt_st.ovf      = (prod[31:16] != 16'h0000);
          end
          mdu_pkg::OP_NORM:
          begin
            // store normalized value and zero count
            nxt_st.md[31:0] = norm_res;
            nxt_st.sc       = opnd_zero ? 5'h1F : lz;
            nxt_st.ovf      = dvd32[31];
          end
          default:
          begin
            // shift result back into bytes 0-3
            nxt_st.md[31:0] = shift_res;
            nxt_st.ovf      = 1'b0;
          end
        endcase
      end
    end

    if (wr_acc)
    begin
      if (st_ff.phase == mdu_pkg::PH_BUSY)
      begin
        // write during operation is refused and flagged
        nxt_st.err = 1'b1;
      end
      else
      begin
        unique case (idx)
          mdu_pkg::IDX_OPERAND_BYTE0:
          begin
            // opening write resets the unit and arms error tracking
            nxt_st.md[7:0]  = wbyte;
            nxt_st.phase    = mdu_pkg::PH_LOAD;
            nxt_st.hi_seen  = 1'b0;
            nxt_st.wr1_seen = 1'b0;
            nxt_st.mul_ord  = 1'b0;
            nxt_st.err      = 1'b0;
            nxt_st.ovf      = 1'b0;
          end
          mdu_pkg::IDX_OPERAND_BYTE1:
          begin
            nxt_st.md[15:8] = wbyte;
            nxt_st.wr1_seen = 1'b1;
          end
          mdu_pkg::IDX_OPERAND_BYTE2:
          begin
            nxt_st.md[23:16] = wbyte;
            nxt_st.hi_seen   = 1'b1;
          end
          mdu_pkg::IDX_OPERAND_BYTE3:
          begin
            nxt_st.md[31:24] = wbyte;
            nxt_st.hi_seen   = 1'b1;
          end
          mdu_pkg::IDX_OPERAND_BYTE4:
          begin
            nxt_st.md[39:32] = wbyte;
            // Byte 4 ahead of byte 1 marks the multiply order
            if (!st_ff.wr1_seen)
              nxt_st.mul_ord = 1'b1;
          end
          mdu_pkg::IDX_OPERAND_BYTE5:
          begin
            nxt_st.md[47:40] = wbyte;
            if (st_ff.phase == mdu_pkg::PH_LOAD)
            begin
              // final loading write starts the latency count
              nxt_st.phase = mdu_pkg::PH_BUSY;
              if (st_ff.mul_ord)
              begin
                nxt_st.op  = mdu_pkg::OP_MUL;
                nxt_st.cnt = mdu_pkg::LAT_MUL - mdu_pkg::CNT_ONE;
              end
              else if (st_ff.hi_seen)
              begin
                nxt_st.op  = mdu_pkg::OP_DIV32;
                nxt_st.cnt = mdu_pkg::LAT_DIV32 - mdu_pkg::CNT_ONE;
              end
              else
              begin
                nxt_st.op  = mdu_pkg::OP_DIV16;
                nxt_st.cnt = mdu_pkg::LAT_DIV16 - mdu_pkg::CNT_ONE;
              end
            end
          end
          default:
          begin
            nxt_st.shift_direction_select   = wbyte[mdu_pkg::ARC_SLR_BIT];
            nxt_st.sc    = wbyte[mdu_pkg::ARC_SC_MSB:0];
            nxt_st.op    = (wbyte[mdu_pkg::ARC_SC_MSB:0] == 5'h00) ?
                           mdu_pkg::OP_NORM : mdu_pkg::OP_SHIFT;
            nxt_st.phase = mdu_pkg::PH_BUSY;
            nxt_st.cnt   = mdu_pkg::LAT_SHIFT - mdu_pkg::CNT_ONE;
          end
        endcase
      end
    end

    if (rd_acc && (idx == mdu_pkg::IDX_ARITH_CONTROL))
    begin
      nxt_st.err = 1'b0;
      // control read ends the result sequence
      if (st_ff.phase == mdu_pkg::PH_RESULT)
        nxt_st.phase = mdu_pkg::PH_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.md       <= mdu_pkg::RST_OPERANDS;
      st_ff.err      <= 1'b0;
      st_ff.ovf      <= 1'b0;
      st_ff.shift_direction_select      <= 1'b0;
      st_ff.sc       <= mdu_pkg::RST_SC;
      st_ff.phase    <= mdu_pkg::PH_IDLE;
      st_ff.op       <= mdu_pkg::OP_DIV32;
      st_ff.cnt      <= 5'h00;
      st_ff.hi_seen  <= 1'b0;
      st_ff.wr1_seen <= 1'b0;
      st_ff.mul_ord  <= 1'b0;
      st_ff.rdata    <= mdu_pkg::RST_BYTE;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic start_md5;
  assign start_md5 = wr_acc && (idx == mdu_pkg::IDX_OPERAND_BYTE5) &&
                     (st_ff.phase == mdu_pkg::PH_LOAD);

  a_div32_latency: assert property (@(posedge pclk) disable iff (!presetn)
    start_md5 && !st_ff.mul_ord && st_ff.hi_seen
    |-> ##17 (st_ff.phase == mdu_pkg::PH_BUSY) ##1 (st_ff.phase == mdu_pkg::PH_RESULT))
    else $error("long division latency wrong");

  a_div16_latency: assert property (@(posedge pclk) disable iff (!presetn)
    start_md5 && !st_ff.mul_ord && !st_ff.hi_seen
    |-> ##9 (st_ff.phase == mdu_pkg::PH_BUSY) ##1 (st_ff.phase == mdu_pkg::PH_RESULT))
    else $error("short division latency wrong");

  a_mul_latency: assert property (@(posedge pclk) disable iff (!presetn)
    start_md5 && st_ff.mul_ord
    |-> ##10 (st_ff.phase == mdu_pkg::PH_BUSY) ##1 (st_ff.phase == mdu_pkg::PH_RESULT))
    else $error("multiply latency wrong");

  a_busy_write_err: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && (st_ff.phase == mdu_pkg::PH_BUSY) |=> st_ff.err && $stable(st_ff.md[47:32]))
    else $error("busy write not flagged");

  a_ctrl_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && (idx == mdu_pkg::IDX_ARITH_CONTROL) |=> !st_ff.err)
    else $error("control read kept error flag");

  a_div_zero_ovf: assert property (@(posedge pclk) disable iff (!presetn)
    done && dvs_zero && (st_ff.op inside {mdu_pkg::OP_DIV32, mdu_pkg::OP_DIV16})
    |=> st_ff.ovf && (st_ff.phase == mdu_pkg::PH_RESULT))
    else $error("zero divisor not flagged");

  a_mul_product: assert property (@(posedge pclk) disable iff (!presetn)
    done && (st_ff.op == mdu_pkg::OP_MUL)
    |=> (st_ff.md[31:0] == $past(st_ff.md[15:0]) * $past(st_ff.md[47:32]))
        && (st_ff.ovf == ($past(st_ff.md[15:0]) * $past(st_ff.md[47:32]) > 32'h0000FFFF)))
    else $error("product or overflow wrong");

  a_shift_result: assert property (@(posedge pclk) disable iff (!presetn)
    done && (st_ff.op == mdu_pkg::OP_SHIFT) && st_ff.shift_direction_select
    |=> st_ff.md[31:0] == ($past(st_ff.md[31:0]) >> st_ff.sc))
    else $error("right shift result wrong");

  a_norm_result: assert property (@(posedge pclk) disable iff (!presetn)
    done && (st_ff.op == mdu_pkg::OP_NORM) && !opnd_zero
    |=> st_ff.md[31] && (st_ff.md[31:0] == ($past(st_ff.md[31:0]) << st_ff.sc)))
    else $error("normalization wrong");

  a_seq_ready: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && (idx == mdu_pkg::IDX_ARITH_CONTROL) && (st_ff.phase == mdu_pkg::PH_RESULT)
    |=> st_ff.phase == mdu_pkg::PH_IDLE)
    else $error("unit not ready after reads");

  a_open_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && (idx == mdu_pkg::IDX_OPERAND_BYTE0) && (st_ff.phase != mdu_pkg::PH_BUSY)
    |=> (st_ff.phase == mdu_pkg::PH_LOAD) && !st_ff.err && !st_ff.ovf)
    else $error("opening write did not reset");

endmodule : mul_div_shift_unit

// >>> sim/mdu_cpu_model.sv
`timescale 1ns/10ps
// ============================================================================
// CPU side of the register bus
// ============================================================================
module mdu_cpu_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // one access at a time
  // Caller enters just after a rising edge; one idle cycle follows each access
  // No wait limit here: only the bench watchdog may end a stuck access
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not look like a held request
    paddr <= ~addr;
    pwdata <= ~wd;
    @(posedge pclk);
  endtask : xfer
endmodule : mdu_cpu_model

// >>> sim/mul_div_shift_unit_tb.sv
`timescale 1ns/10ps
module mul_div_shift_unit_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          samples_checked;
  int          kind;
  // loading orders; 6 is the control register
  int          w_ord [4][6] = '{'{0,1,2,3,4,5}, '{0,1,4,5,-1,-1}, '{0,4,1,5,-1,-1},
                                '{0,1,2,3,6,-1}};
  int          r_ord [4][7] = '{'{0,1,2,3,4,5,6}, '{0,1,4,5,6,-1,-1},
                                '{0,1,2,3,6,-1,-1}, '{0,1,2,3,6,-1,-1}};
  // idle time before reading; shifts wait 20 cycles, well past their fixed 3
  int          lat   [4]    = '{17, 9, 10, 20};

  mdu_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  mul_div_shift_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ==========================================================================
  // Checking helpers
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  function automatic logic [11:0] reg_addr(input int n);
    return {2'b00, mdu_pkg::IDX_OPERAND_BYTE0 + 8'(n), 2'b00};
  endfunction : reg_addr

  // Result layout: {control, byte5, byte4, byte3..byte0}
  function automatic logic [55:0] model_op(input int k, input logic [31:0] a,
                                           input logic [15:0] b, input logic [7:0] ctl);
    logic [31:0] r;
    logic [31:0] dv;
    logic [15:0] m;
    logic [4:0]  sc;
    logic        ovf;
    dv = (k == 1) ? {16'h0000, a[15:0]} : a;
    sc = ctl[4:0];
    ovf = 1'b0;
    m = 16'h0000;
    r = 32'h00000000;
    if (k < 2)
    begin
      ovf = (b == 16'h0000);
      r = ovf ? 32'h00000000 : dv / b;
      m = ovf ? 16'h0000 : 16'(dv % b);
    end
    else if (k == 2)
    begin
      r = a[15:0] * b;
      ovf = (r > 32'h0000FFFF);
    end
    else if (sc != 5'h00)
      r = ctl[5] ? a >> sc : a << sc;
    else if (a[31])
    begin
      ovf = 1'b1;
      r = a;
    end
    else if (a == 32'h00000000)
      sc = 5'h1F;
    else
    begin
      r = a;
      while (!r[31])
      begin
        r = r << 1;
        sc++;
      end
    end
    return {1'b0, ovf, ctl[5], sc, m, r};
  endfunction : model_op

  // ==========================================================================
  // One whole operation: load, optional write while busy, wait, read back
  // ==========================================================================
  task automatic run_op(input int k, input logic [31:0] a, input logic [15:0] b,
                        input logic [7:0] ctl, input logic intrude);
    logic [55:0] e;
    logic [55:0] ops;
    logic [31:0] mask;
    e = model_op(k, a, b, ctl);
    ops = {ctl, b, a};
    e[55] = intrude;
    mask = (k == 3) ? 32'h000000FF : 32'h000000C0;
    // Only the row of this operation is walked
    for (int i = 0; i < 6; i++)
      if (w_ord[k][i] >= 0)
        i_cpu.xfer(1'b1, reg_addr(w_ord[k][i]), {24'h0, ops[8*w_ord[k][i] +: 8]}, rd, err);
    if (intrude)
      i_cpu.xfer(1'b1, reg_addr(0), {24'h0, ~a[7:0]}, rd, err);
    // wait counted from the last loading write; read data is taken at setup
    repeat (intrude ? lat[k] : lat[k] - 1) @(posedge pclk);
    for (int i = 0; i < 7; i++)
      if (r_ord[k][i] >= 0)
      begin
        i_cpu.xfer(1'b0, reg_addr(r_ord[k][i]), 32'h0, rd, err);
        if (r_ord[k][i] < 6)
          check(rd, {24'h0, e[8*r_ord[k][i] +: 8]});
        else
          check(rd & mask, {24'h0, e[55:48]} & mask);
      end
    i_cpu.xfer(1'b0, reg_addr(6), 32'h0, rd, err);
    check(rd & 32'h80, 32'h0);
  endtask : run_op

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    failures = 0;
    samples_checked = 0;
    presetn = 1'b0;
    void'($urandom(86700));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int n = 0; n < 7; n++)
    begin
      i_cpu.xfer(1'b0, reg_addr(n), 32'h0, rd, err);
      check(rd, 32'h0);
    end
    i_cpu.xfer(1'b0, 12'h000, 32'h0, rd, err);
    check({rd[31:1], err}, 32'h1);
    i_cpu.xfer(1'b0, 12'h3E5, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    $display("test register_map done");
    run_op(0, 32'hFFFFFFFF, 16'h0001, 8'h00, 1'b0);
    run_op(0, 32'h12345678, 16'h0000, 8'h00, 1'b0);
    run_op(1, 32'h0000FFFF, 16'hFFFF, 8'h00, 1'b0);
    run_op(2, 32'h000000FF, 16'h0101, 8'h00, 1'b0);
    run_op(2, 32'h0000FFFF, 16'hFFFF, 8'h00, 1'b0);
    run_op(3, 32'h00000000, 16'h0000, 8'h00, 1'b0);
    run_op(3, 32'h00000001, 16'h0000, 8'h00, 1'b0);
    run_op(3, 32'h80000001, 16'h0000, 8'h00, 1'b0);
    run_op(3, 32'h80000001, 16'h0000, 8'h3F, 1'b0);
    run_op(3, 32'h80000001, 16'h0000, 8'h1F, 1'b0);
    // write while busy, then the next operation still works
    run_op(0, 32'hCAFE1234, 16'h00F1, 8'h00, 1'b1);
    run_op(2, 32'h00001234, 16'h5678, 8'h00, 1'b1);
    $display("test corner_cases done");
    for (int i = 0; i < 48; i++)
    begin
      kind = $urandom_range(3);
      run_op(kind, $urandom, 16'($urandom_range(65535, 1)), 8'($urandom_range(63)),
             (kind < 3) && (i % 8 == 7));
    end
    $display("test random_ops done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end
endmodule : mul_div_shift_unit_tb
